// ---- logic/aisc_top.sv ----
// Amplifier control and input source selection register bank with APB access.
// Assumes synchronous pin inputs at the 25 MHz clock and an APB master.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - bit 7 bypasses the amplifier
// - positive codes 0011-1000 select inputs 0-5
// - positive code 1011 selects temperature sensor
// - positive 1110 open, 1111 common, reset
// - negative codes 0011-1000 inputs, reset 1111
// - negative code 1011 selects temperature sensor
// - negative code 1110 leaves input open
// - chip select low keeps interface enabled
// - grounded clock input uses internal oscillator
// - start pin low commands, high free-runs
// - reset by power-on, pin or command
// - power-down by pin low or command
// - combined pin drives only when selected
// - data ready also readable by polling
// - results buffered, readable any time
// - excitation drives follow conversion cycles
// - excitation drives never overlap
module aisc_top (
  // Clock and reset.
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RST_IN,
  // APB slave.
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  output logic [31:0]      PRDATA_OUT,
  // Device pins.
  input  wire logic        CHIP_SELECT_N_IN,
  input  wire logic        EXTERNAL_CLOCK_INPUT_IN,
  input  wire logic        START_IN,
  input  wire logic        RESET_PIN_N_IN,
  input  wire logic        POWER_DOWN_PIN_N_IN,
  output logic             DATA_READY_PIN_N_OUT,
  output logic             SERIAL_OUT_READY_PIN_OUT,
  output logic             SERIAL_OUT_READY_PIN_OE_OUT,
  // Analog routing controls.
  output logic             AMP_BYPASS_OUT,
  output logic [2:0]       AMP_GAIN_OUT,
  output logic [5:0]       POS_INPUT_SEL_OUT,
  output logic [5:0]       NEG_INPUT_SEL_OUT,
  output logic             POS_TEMP_SEL_OUT,
  output logic             NEG_TEMP_SEL_OUT,
  output logic             POS_VCOM_SEL_OUT,
  output logic             NEG_VCOM_SEL_OUT,
  output logic             USE_INT_OSC_OUT,
  output logic             POWERED_DOWN_OUT,
  // Excitation and conversion data.
  input  wire logic [23:0] CONV_RESULT_IN,
  output logic             EXC_DRIVE_A_OUT,
  output logic             EXC_DRIVE_B_OUT
);
  import aisc_pkg::*;

  typedef struct packed {
    logic [7:0]  amp;
    logic [7:0]  src;
    logic        run;
    logic        cont;
    logic        pdown;
    logic        exc_en;
    logic        data_ready_pin;
    logic [23:0] result;
    logic [15:0] conv_cnt;
    logic        flip;
    logic [31:0] rdata;
  } aisc_top_s;

  aisc_top_s st_reg;
  aisc_top_s st_next;

  logic       apb_access;
  logic       apb_wr;
  logic       apb_rd;
  logic       addr_ok;
  logic       soft_reset;
  logic       conv_done;
  logic       running;
  logic [31:0] rd_mux;

  // Decode a 4-bit source code into one-hot input selects.
  function automatic logic [5:0] aisc_decode_src(input logic [3:0] code);
    logic [5:0] sel;
    sel = 6'h00;
    if (code >= AISC_SRC_ANALOG_INPUT_0 && code <= AISC_SRC_AIN5) begin
      sel = 6'(6'h01 << (code - AISC_SRC_ANALOG_INPUT_0));
    end
    return sel;
  endfunction

  // Valid address check shared by read and write paths.
  function automatic logic aisc_addr_valid(input logic [11:0] a);
    return (a == AISC_AMP_ADDR) || (a == AISC_SRC_ADDR) || (a == AISC_CTRL_ADDR) ||
           (a == AISC_STAT_ADDR) || (a == AISC_DATA_ADDR) || (a == AISC_EXC_ADDR);
  endfunction

  // APB handshake; the slave answers in the first access cycle.
  assign apb_access  = PSEL_IN && PENABLE_IN;
  assign addr_ok     = aisc_addr_valid(PADDR_IN);
  assign apb_wr      = apb_access && PWRITE_IN && addr_ok;
  assign apb_rd      = PSEL_IN && !PENABLE_IN && !PWRITE_IN;
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = apb_access && !addr_ok;

  assign soft_reset = !RESET_PIN_N_IN || (apb_wr && PADDR_IN == AISC_CTRL_ADDR &&
                      PWDATA_IN[AISC_CTRL_RESET_BIT]);
  assign running    = !st_reg.pdown && (st_reg.run || START_IN);
  assign conv_done  = running && st_reg.conv_cnt == AISC_CONV_CYC;

  // Read mux, captured in the setup cycle so read data comes from flip-flops.
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (PADDR_IN)
      AISC_AMP_ADDR:  rd_mux = {24'h00_0000, st_reg.amp};
      AISC_SRC_ADDR:  rd_mux = {24'h00_0000, st_reg.src};
      AISC_CTRL_ADDR: rd_mux = {26'h000_0000, st_reg.cont, 4'h0, st_reg.run};
      AISC_STAT_ADDR: rd_mux = {29'h0000_0000, st_reg.pdown, running, st_reg.data_ready_pin};
      AISC_DATA_ADDR: rd_mux = {8'h00, st_reg.result};
      AISC_EXC_ADDR:  rd_mux = {31'h0000_0000, st_reg.exc_en};
      default:        rd_mux = 32'h0000_0000;
    endcase
  end

  // Next-state logic for registers, control and conversion sequencing.
  always_comb begin
    st_next = st_reg;
    st_next.flip = 1'b0;
    if (apb_rd) begin
      st_next.rdata = rd_mux;
    end
    if (apb_wr) begin
      case (PADDR_IN)
        AISC_AMP_ADDR: st_next.amp = PWDATA_IN[7:0] & AISC_AMP_WMASK;
        AISC_SRC_ADDR: st_next.src = PWDATA_IN[7:0];
        AISC_CTRL_ADDR: begin
          st_next.cont = PWDATA_IN[AISC_CTRL_CONT_BIT];
          if (PWDATA_IN[AISC_CTRL_START_BIT]) begin
            st_next.run = 1'b1;
          end
          if (PWDATA_IN[AISC_CTRL_STOP_BIT]) begin
            st_next.run = 1'b0;
          end
          if (PWDATA_IN[AISC_CTRL_PDOWN_BIT]) begin
            st_next.pdown = 1'b1;
          end
          if (PWDATA_IN[AISC_CTRL_WAKE_BIT]) begin
            st_next.pdown = 1'b0;
          end
        end
        AISC_EXC_ADDR: st_next.exc_en = PWDATA_IN[0];
        default: st_next.cont = st_reg.cont;
      endcase
    end
    if (!POWER_DOWN_PIN_N_IN) begin
      st_next.pdown = 1'b1;
    end
    // Reading the result clears data ready in the cycle that captures it, so a result
    // landing during the access phase keeps its flag; a new result in this cycle wins.
    if (apb_rd && PADDR_IN == AISC_DATA_ADDR) begin
      st_next.data_ready_pin = 1'b0;
    end
    if (running) begin
      st_next.conv_cnt = conv_done ? 16'h0000 : st_reg.conv_cnt + 16'h0001;
    end else begin
      st_next.conv_cnt = 16'h0000;
    end
    if (conv_done) begin
      st_next.result = CONV_RESULT_IN;
      st_next.data_ready_pin = 1'b1;
      st_next.flip = 1'b1;
      // One-shot mode ends after a single conversion.
      if (!st_reg.cont && !START_IN) begin
        st_next.run = 1'b0;
      end
    end
    if (soft_reset) begin
      st_next = '0;
      st_next.amp = AISC_AMP_RST;
      st_next.src = AISC_SRC_RST;
    end
  end

  // State register.
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      st_reg <= '0;
      st_reg.amp <= AISC_AMP_RST;
      st_reg.src <= AISC_SRC_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign PRDATA_OUT = st_reg.rdata;

  assign AMP_BYPASS_OUT = st_reg.amp[AISC_BYPASS_BIT];
  assign AMP_GAIN_OUT   = st_reg.amp[2:0];

  assign POS_INPUT_SEL_OUT = aisc_decode_src(st_reg.src[7:4]);
  assign POS_TEMP_SEL_OUT  = st_reg.src[7:4] == AISC_SRC_TEMP;
  assign POS_VCOM_SEL_OUT  = st_reg.src[7:4] == AISC_SRC_VCOM;
  assign NEG_INPUT_SEL_OUT = aisc_decode_src(st_reg.src[3:0]);
  assign NEG_TEMP_SEL_OUT  = st_reg.src[3:0] == AISC_SRC_TEMP;
  // negative open leaves all selects low
  assign NEG_VCOM_SEL_OUT  = st_reg.src[3:0] == AISC_SRC_VCOM;

  assign USE_INT_OSC_OUT  = !EXTERNAL_CLOCK_INPUT_IN;
  assign POWERED_DOWN_OUT = st_reg.pdown;

  assign DATA_READY_PIN_N_OUT        = !st_reg.data_ready_pin;
  assign SERIAL_OUT_READY_PIN_OUT    = !st_reg.data_ready_pin;
  assign SERIAL_OUT_READY_PIN_OE_OUT = !CHIP_SELECT_N_IN;

  // Excitation drive generator.
  aisc_excite u_excite (
    .CLK_SYS_IN  (CLK_SYS_IN),
    .RST_IN      (RST_IN),
    .enable_in   (st_reg.exc_en && running),
    .flip_in     (st_reg.flip),
    .drive_a_out (EXC_DRIVE_A_OUT),
    .drive_b_out (EXC_DRIVE_B_OUT)
  );

  a_bypass_write: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN || !RESET_PIN_N_IN)
    apb_wr && PADDR_IN == AISC_AMP_ADDR |=> AMP_BYPASS_OUT == $past(PWDATA_IN[7]))
    else $error("bypass bit not stored");
  a_gain_store: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    apb_wr && PADDR_IN == AISC_AMP_ADDR && !soft_reset |=> AMP_GAIN_OUT == $past(PWDATA_IN[2:0]))
    else $error("gain code not stored");
  a_reserved_zero: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN) st_reg.amp[6:3] == 4'h0)
    else $error("reserved amplifier bits set");
  a_pos_input: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    st_reg.src[7:4] == 4'h3 |-> POS_INPUT_SEL_OUT == 6'h01)
    else $error("positive input 0 not selected");
  a_pos_temp: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    POS_TEMP_SEL_OUT |-> POS_INPUT_SEL_OUT == 6'h00 && !POS_VCOM_SEL_OUT)
    else $error("temperature route overlaps");
  a_pos_open: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    st_reg.src[7:4] == 4'hE |-> !POS_TEMP_SEL_OUT && !POS_VCOM_SEL_OUT && POS_INPUT_SEL_OUT == 6'h00)
    else $error("open positive input driven");
  a_pos_common: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    st_reg.src[7:4] == AISC_SRC_VCOM |-> POS_VCOM_SEL_OUT && !POS_TEMP_SEL_OUT && POS_INPUT_SEL_OUT == 6'h00)
    else $error("positive common route overlaps");
  a_neg_input: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    st_reg.src[3:0] == 4'h8 |-> NEG_INPUT_SEL_OUT == 6'h20)
    else $error("negative input 5 not selected");
  a_neg_common: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    st_reg.src[3:0] == AISC_SRC_VCOM |-> NEG_VCOM_SEL_OUT && !NEG_TEMP_SEL_OUT && NEG_INPUT_SEL_OUT == 6'h00)
    else $error("negative common route overlaps");
  a_neg_temp: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    st_reg.src[3:0] == 4'hB |-> NEG_TEMP_SEL_OUT)
    else $error("negative temperature not routed");
  a_neg_excl: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    NEG_TEMP_SEL_OUT |-> NEG_INPUT_SEL_OUT == 6'h00 && !NEG_VCOM_SEL_OUT)
    else $error("negative temperature route overlaps");
  a_neg_open: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    st_reg.src[3:0] == 4'hE |-> !NEG_VCOM_SEL_OUT && NEG_INPUT_SEL_OUT == 6'h00)
    else $error("open negative input driven");
  a_pin_enable: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    !CHIP_SELECT_N_IN |-> SERIAL_OUT_READY_PIN_OE_OUT)
    else $error("selected pin not driven");
  a_int_osc: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    !EXTERNAL_CLOCK_INPUT_IN |-> USE_INT_OSC_OUT)
    else $error("internal oscillator not chosen");
  a_start_run: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    START_IN && !st_reg.pdown |-> running)
    else $error("start pin does not run");
  a_one_shot: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    conv_done && !st_reg.cont && !START_IN |=> !st_reg.run)
    else $error("one-shot conversion kept running");
  a_pin_reset: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    !RESET_PIN_N_IN |=> st_reg.src == AISC_SRC_RST && st_reg.amp == AISC_AMP_RST)
    else $error("pin reset not applied");
  a_cmd_reset: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    apb_wr && PADDR_IN == AISC_CTRL_ADDR && PWDATA_IN[AISC_CTRL_RESET_BIT] |=>
    st_reg.src == AISC_SRC_RST && st_reg.amp == AISC_AMP_RST && !st_reg.run)
    else $error("command reset not applied");
  a_pin_pdown: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    !POWER_DOWN_PIN_N_IN && RESET_PIN_N_IN |=> POWERED_DOWN_OUT)
    else $error("power-down pin ignored");
  a_pdown_halt: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    st_reg.pdown |-> !running)
    else $error("conversions run while powered down");
  a_data_ready_pin_mirror: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    SERIAL_OUT_READY_PIN_OUT == DATA_READY_PIN_N_OUT)
    else $error("combined pin not mirroring ready");
  a_pin_quiet: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    CHIP_SELECT_N_IN |-> !SERIAL_OUT_READY_PIN_OE_OUT)
    else $error("deselected pin driven");
  a_status_poll: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    apb_rd && PADDR_IN == AISC_STAT_ADDR && !soft_reset |=> PRDATA_OUT[0] == $past(st_reg.data_ready_pin))
    else $error("polled ready wrong");
  a_result_hold: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN || !RESET_PIN_N_IN)
    conv_done && !soft_reset |=> st_reg.data_ready_pin && st_reg.result == $past(CONV_RESULT_IN))
    else $error("result not buffered");
  a_read_clear: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    apb_rd && PADDR_IN == AISC_DATA_ADDR && !conv_done |=> !st_reg.data_ready_pin)
    else $error("result read left ready set");
  a_flip_follow: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    conv_done && !soft_reset |=> st_reg.flip)
    else $error("polarity flip missing");
endmodule
`default_nettype wire

// ---- logic/aisc_pkg.sv ----
// Package for the amplifier and input select configuration block.
// Assumes one 25 MHz system clock and an APB register port.
package aisc_pkg;
  // Register word indices, and offsets (byte addresses on APB, word aligned).
  localparam logic [7:0] AISC_AMP_IDX       = 8'h10;
  localparam logic [7:0] AISC_SRC_IDX       = 8'h11;
  localparam logic [11:0] AISC_AMP_ADDR     = 12'h040;
  localparam logic [11:0] AISC_SRC_ADDR     = 12'h044;
  localparam logic [11:0] AISC_CTRL_ADDR    = 12'h048;
  localparam logic [11:0] AISC_STAT_ADDR    = 12'h04C;
  localparam logic [11:0] AISC_DATA_ADDR    = 12'h050;
  localparam logic [11:0] AISC_EXC_ADDR     = 12'h054;
  // Reset values.
  localparam logic [7:0] AISC_AMP_RST       = 8'h00;
  localparam logic [7:0] AISC_SRC_RST       = 8'hFF;
  // Field positions.
  localparam int AISC_BYPASS_BIT            = 7;
  localparam logic [7:0] AISC_AMP_WMASK     = 8'h87;
  // Control register bits.
  localparam int AISC_CTRL_START_BIT        = 0;
  localparam int AISC_CTRL_STOP_BIT         = 1;
  localparam int AISC_CTRL_RESET_BIT        = 2;
  localparam int AISC_CTRL_PDOWN_BIT        = 3;
  localparam int AISC_CTRL_WAKE_BIT         = 4;
  localparam int AISC_CTRL_CONT_BIT         = 5;
  // Source codes.
  localparam logic [3:0] AISC_SRC_ANALOG_INPUT_0      = 4'h3;
  localparam logic [3:0] AISC_SRC_AIN5      = 4'h8;
  localparam logic [3:0] AISC_SRC_TEMP      = 4'hB;
  localparam logic [3:0] AISC_SRC_OPEN      = 4'hE;
  localparam logic [3:0] AISC_SRC_VCOM      = 4'hF;
  // Conversion and excitation timing.
  localparam int AISC_CLK_MHZ               = 25;
  localparam int AISC_GAP_NS                = 400;
  localparam int AISC_GAP_CYC = (AISC_GAP_NS * AISC_CLK_MHZ + 999) / 1000;
  localparam logic [15:0] AISC_CONV_CYC     = 16'h0100;
  // Gain codes.
  localparam logic [2:0] AISC_GAIN_1        = 3'h0;
  localparam logic [2:0] AISC_GAIN_64       = 3'h6;
  localparam logic [2:0] AISC_GAIN_128      = 3'h7;
endpackage

// ---- logic/aisc_excite.sv ----
// Alternating bridge excitation drive with a non-overlap gap.
// Assumes a one-cycle phase toggle pulse from the conversion sequencer.
`timescale 1ns/100ps
`default_nettype none
module aisc_excite (
  // Clock and reset.
  input  wire logic CLK_SYS_IN,
  input  wire logic RST_IN,
  // Control.
  input  wire logic enable_in,
  input  wire logic flip_in,
  // Drives.
  output logic      drive_a_out,
  output logic      drive_b_out
);
  import aisc_pkg::*;

  typedef struct packed {
    logic       phase;
    logic       a;
    logic       b;
    logic [7:0] gap;
  } aisc_exc_s;

  aisc_exc_s st_reg;
  aisc_exc_s st_next;

  // Both drives drop first, then the new side rises after the gap.
  always_comb begin
    st_next = st_reg;
    if (!enable_in) begin
      st_next.a = 1'b0;
      st_next.b = 1'b0;
      st_next.gap = 8'h00;
    end else if (flip_in) begin
      st_next.phase = ~st_reg.phase;
      st_next.a = 1'b0;
      st_next.b = 1'b0;
      st_next.gap = 8'(AISC_GAP_CYC);
    end else if (st_reg.gap != 8'h00) begin
      st_next.gap = st_reg.gap - 8'h01;
    end else begin
      st_next.a = ~st_reg.phase;
      st_next.b = st_reg.phase;
    end
  end

  // State register.
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign drive_a_out = st_reg.a;
  assign drive_b_out = st_reg.b;

  a_no_overlap: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN) !(drive_a_out && drive_b_out))
    else $error("excitation drives overlap");
  a_gap_after_flip: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN) flip_in && enable_in |=> !drive_a_out && !drive_b_out)
    else $error("no gap after flip");
endmodule
`default_nettype wire

// ---- testbench/aisc_host.sv ----
// APB master standing in for the host controller.
// Assumes the slave answers through PREADY sampled at a rising edge.
`timescale 1ns/100ps
`default_nettype none
module aisc_host (
  // Clock.
  input  wire logic        clk_in,
  // Answer.
  input  wire logic        pready_in,
  input  wire logic        pslverr_in,
  input  wire logic [31:0] prdata_in,
  // Request.
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic [11:0]      paddr_out,
  output logic [31:0]      pwdata_out
);
  // The bus idles with strobes low from time zero.
  initial begin
    psel_out    = 1'b0;
    penable_out = 1'b0;
    pwrite_out  = 1'b0;
    paddr_out   = 12'h000;
    pwdata_out  = 32'h0000_0000;
  end

  // One transfer, held until PREADY is seen high at a rising edge.
  // Released lines show inverted values so a stale address never passes.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk_in);
    psel_out    <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out  <= w;
    paddr_out   <= a;
    pwdata_out  <= d;
    @(posedge clk_in);
    penable_out <= 1'b1;
    @(posedge clk_in);
    while (pready_in !== 1'b1) begin
      @(posedge clk_in);
    end
    q = prdata_in;
    e = pslverr_in;
    psel_out    <= 1'b0;
    penable_out <= 1'b0;
    paddr_out   <= ~a;
    pwdata_out  <= ~d;
  endtask
endmodule
`default_nettype wire

// ---- testbench/aisc_top_tb.sv ----
// Self-checking bench for the amplifier and input select block.
// Assumes the host model in aisc_host.sv drives the APB port.
`timescale 1ns/100ps
`default_nettype none
module aisc_top_tb;
  import aisc_pkg::*;
  typedef struct packed {logic [7:0] w; logic [5:0] p; logic [5:0] n; logic [3:0] f;} aisc_row_s;
  // Legal selector codes only; flags are pos temp, neg temp, pos common, neg common.
  // legal codes only.
  localparam aisc_row_s ROWS [9] = '{'{8'h38, 6'h01, 6'h20, 4'h0}, '{8'h47, 6'h02, 6'h10, 4'h0},
    '{8'h56, 6'h04, 6'h08, 4'h0}, '{8'h65, 6'h08, 6'h04, 4'h0}, '{8'h74, 6'h10, 6'h02, 4'h0},
    '{8'h83, 6'h20, 6'h01, 4'h0}, '{8'hBE, 6'h00, 6'h00, 4'h8}, '{8'hEB, 6'h00, 6'h00, 4'h4},
    '{8'hFF, 6'h00, 6'h00, 4'h3}};
  logic        clk = 1'b0, rst = 1'b1, pready, pslverr, psel, pen, pwr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        cs_n = 1'b1, xclk = 1'b0, start = 1'b0, rpin_n = 1'b1, pd_n = 1'b1, e, a0;
  logic [23:0] result = 24'h5A_C3E1;
  logic        data_ready_pin_n, sdo, sdo_oe, byp, pt, nt, pv, nv, osc, pdn, exa, exb;
  logic [2:0]  gain;
  logic [5:0]  psel6, nsel6;
  int          cyc = 0, failures = 0, compares = 0, i;

  aisc_host host (.clk_in(clk), .pready_in(pready), .pslverr_in(pslverr), .prdata_in(prdata),
    .psel_out(psel), .penable_out(pen), .pwrite_out(pwr), .paddr_out(paddr), .pwdata_out(pwdata));
  aisc_top dut (.CLK_SYS_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .PRDATA_OUT(prdata), .CHIP_SELECT_N_IN(cs_n), .EXTERNAL_CLOCK_INPUT_IN(xclk), .START_IN(start),
    .RESET_PIN_N_IN(rpin_n), .POWER_DOWN_PIN_N_IN(pd_n), .DATA_READY_PIN_N_OUT(data_ready_pin_n),
    .SERIAL_OUT_READY_PIN_OUT(sdo), .SERIAL_OUT_READY_PIN_OE_OUT(sdo_oe), .AMP_BYPASS_OUT(byp),
    .AMP_GAIN_OUT(gain), .POS_INPUT_SEL_OUT(psel6), .NEG_INPUT_SEL_OUT(nsel6), .POS_TEMP_SEL_OUT(pt),
    .NEG_TEMP_SEL_OUT(nt), .POS_VCOM_SEL_OUT(pv), .NEG_VCOM_SEL_OUT(nv), .USE_INT_OSC_OUT(osc),
    .POWERED_DOWN_OUT(pdn), .CONV_RESULT_IN(result), .EXC_DRIVE_A_OUT(exa), .EXC_DRIVE_B_OUT(exb));

  // The clock runs at 25 MHz.
  always #20 clk = ~clk;

  task automatic check(input logic [31:0] s, input logic [31:0] x, input string m);
    compares++;
    if (s !== x) begin
      failures++;
      $display("MISMATCH %0t %s seen %h exp %h", $time, m, s, x);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        err;
    host.xfer(1'b1, a, d, r, err);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic err;
    host.xfer(1'b0, a, 32'h0000_0000, r, err);
  endtask

  // Poll the status word until a result is flagged, within a bounded count.
  task automatic poll();
    logic [31:0] r;
    int          n;
    r = 32'h0000_0000;
    for (n = 0; n < 200 && r[0] !== 1'b1; n++) rd(AISC_STAT_ADDR, r);
    check(32'(r[0]), 32'h0000_0001, "ready poll");
  endtask

  task automatic close_out();
    $display("counts failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // The drives must never be high together; a hang is cut short by the cycle ceiling.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!rst) check(32'(exa & exb), 32'h0000_0000, "drive overlap");
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(AISC_AMP_ADDR, q);
    check(q, 32'(AISC_AMP_RST), "amp reset");
    rd(AISC_SRC_ADDR, q);
    check(q, 32'h0000_00FF, "src reset");
    check(32'({byp, gain, pv, nv}), 32'h0000_0003, "reset routing");
    $display("test reset done");
    for (i = 0; i < 9; i++) begin
      wr(AISC_SRC_ADDR, 32'(ROWS[i].w));
      @(posedge clk);
      check(32'({psel6, nsel6}), 32'({ROWS[i].p, ROWS[i].n}), "input select");
      check(32'({pt, nt, pv, nv}), 32'(ROWS[i].f), "special codes");
      rd(AISC_SRC_ADDR, q);
      check(q, 32'(ROWS[i].w), "src readback");
    end
    $display("test select rows done");
    wr(AISC_AMP_ADDR, 32'hFFFF_FFFE);
    @(posedge clk);
    check(32'({byp, gain}), 32'h0000_000E, "bypass gain 64");
    rd(AISC_AMP_ADDR, q);
    check(q, 32'h0000_0086, "reserved amp bits");
    wr(AISC_AMP_ADDR, 32'(AISC_GAIN_128));
    @(posedge clk);
    check(32'({byp, gain}), 32'h0000_0007, "gain 128");
    host.xfer(1'b1, 12'h0FC, 32'hFFFF_FFFF, q, e);
    check(32'(e), 32'h0000_0001, "unmapped write");
    host.xfer(1'b0, 12'h0FC, 32'h0000_0000, q, e);
    check({q[31:1], e}, 32'h0000_0001, "unmapped read");
    rd(AISC_AMP_ADDR, q);
    check(q, 32'h0000_0007, "amp untouched");
    $display("test amplifier done");
    cs_n <= 1'b0;
    xclk <= 1'b1;
    @(posedge clk);
    check(32'({sdo_oe, sdo ^ data_ready_pin_n, osc}), 32'h0000_0004, "selected pin");
    cs_n <= 1'b1;
    xclk <= 1'b0;
    @(posedge clk);
    check(32'({sdo_oe, osc}), 32'h0000_0001, "released pin");
    $display("test pins done");
    wr(AISC_CTRL_ADDR, 32'h0000_0002);
    wr(AISC_SRC_ADDR, 32'h0000_0038);
    wr(AISC_EXC_ADDR, 32'h0000_0001);
    repeat (AISC_GAP_CYC) @(posedge clk);
    start <= 1'b1;
    cs_n <= 1'b0;
    poll();
    check(32'({data_ready_pin_n, sdo}), 32'h0000_0000, "ready pins low");
    rd(AISC_DATA_ADDR, q);
    check(q, 32'(result), "buffered result");
    @(posedge clk);
    check(32'(data_ready_pin_n), 32'h0000_0001, "ready cleared");
    repeat (14) @(posedge clk);
    check(32'(exa ^ exb), 32'h0000_0001, "one drive on");
    a0 = exa;
    poll();
    repeat (14) @(posedge clk);
    check(32'(exa), 32'(!a0), "drive swapped");
    start <= 1'b0;
    rd(AISC_DATA_ADDR, q);
    repeat (300) @(posedge clk);
    rd(AISC_STAT_ADDR, q);
    check(32'(q[0]), 32'h0000_0000, "no free run");
    wr(AISC_CTRL_ADDR, 32'h0000_0001);
    poll();
    rd(AISC_STAT_ADDR, q);
    check(32'(q[2:0]), 32'h0000_0001, "one shot");
    $display("test conversion done");
    pd_n <= 1'b0;
    repeat (2) @(posedge clk);
    pd_n <= 1'b1;
    check(32'(pdn), 32'h0000_0001, "pin power down");
    wr(AISC_CTRL_ADDR, 32'h0000_0010);
    @(posedge clk);
    check(32'(pdn), 32'h0000_0000, "wake");
    wr(AISC_CTRL_ADDR, 32'h0000_0008);
    rd(AISC_STAT_ADDR, q);
    check(32'(q[2]), 32'h0000_0001, "command power down");
    wr(AISC_CTRL_ADDR, 32'h0000_0010);
    $display("test power down done");
    wr(AISC_SRC_ADDR, 32'h0000_0038);
    rpin_n <= 1'b0;
    @(posedge clk);
    rpin_n <= 1'b1;
    rd(AISC_SRC_ADDR, q);
    check(q, 32'h0000_00FF, "pin reset");
    wr(AISC_SRC_ADDR, 32'h0000_0038);
    wr(AISC_CTRL_ADDR, 32'h0000_0004);
    rd(AISC_SRC_ADDR, q);
    check(q, 32'h0000_00FF, "command reset");
    wr(AISC_AMP_ADDR, 32'h0000_0087);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(AISC_AMP_ADDR, q);
    check(q, 32'h0000_0000, "second reset");
    $display("test resets done");
    close_out();
  end
endmodule
`default_nettype wire
